/* rtc_time_date_counters.sv */
// seconds to weekday counters in bcd with register access
`timescale 1ns/10ps
`include "rtc_defines.svh"
// Operation
// RULE_01 - seconds sit in bits 6:0 of offset 08h as bcd, bit 7 unused.
// RULE_02 - seconds count 00 to 59 each tick and cascade into minutes and hours.
// RULE_03 - minutes sit in bits 6:0 of offset 09h as bcd 0 to 59.
// RULE_04 - hours bit 6 high selects 12-hour mode, low selects 24-hour mode.
// RULE_05 - in 12-hour mode bit 5 is pm and bits 4:0 hold hour 1 to 12.
// RULE_06 - in 24-hour mode bits 5:0 hold hour 0 to 23 in bcd.
// RULE_07 - day of month sits in bits 5:0 of offset 0bh as bcd 1 to 31.
// RULE_08 - february gets day 29 when the year value divides by four, 00 included.
// RULE_09 - day wraps to 1 after the month's last day, bumping month and weekday.
// RULE_10 - weekday in bits 2:0 of offset 0ch counts 1 to 7.
// RULE_11 - software names weekdays itself; hardware only cycles them.
// RULE_12 - host writes only valid bcd values.
// RULE_13 - unimplemented bits always read as zero.
module rtc_time_date_counters
    import rtc_pkg::*;
(
    input  wire logic       MCLK,         // 50 mhz system clock
    input  wire logic       RESET,        // synchronous reset, active high
    input  wire logic       SECOND_TICK,  // one-cycle pulse once per second
    input  wire logic [7:0] ADDR,         // register offset
    input  wire logic       WRITE,        // write strobe, one cycle
    input  wire logic [7:0] WDATA,        // write data
    input  wire logic       READ,         // read strobe, one cycle
    output logic      [7:0] RDATA,        // read data, valid cycle after read
    input  wire logic [4:0] MONTH,        // current month in bcd
    input  wire logic [6:0] YEAR,         // current year in bcd
    output logic            MONTH_INC     // pulse: day wrapped, advance month
);
    rtc_state_t state;
    rtc_state_t next_state;

    logic [6:0] sec_next;
    logic       sec_wrap;
    logic [6:0] min_next;
    logic       min_wrap;
    logic [5:0] h24_next;
    logic       h24_wrap;
    logic [4:0] h12_next;
    logic       day_roll;     // midnight reached on this tick
    logic [5:0] day_next;
    logic       day_wrap;
    logic [5:0] last_day;
    logic       leap_year;
    logic       format_12h;
    logic       pm_or_tens_twenty_bit;

    // seconds, minutes and 24-hour steppers
    rtc_bcd_inc #(.WIDTH(7)) u_sec (
        .value   (state.seconds),
        .limit   (`BCD_59),
        .reload  (`RESET_SECONDS),
        .result  (sec_next),
        .wrapped (sec_wrap)
    );
    rtc_bcd_inc #(.WIDTH(7)) u_min (
        .value   (state.minutes),
        .limit   (`BCD_59),
        .reload  (`RESET_MINUTES),
        .result  (min_next),
        .wrapped (min_wrap)
    );
    rtc_bcd_inc #(.WIDTH(6)) u_h24 (
        .value   (state.hours[5:0]),
        .limit   (`BCD_23),
        .reload  (`BCD_HOUR_00),
        .result  (h24_next),
        .wrapped (h24_wrap)
    );
    // 12-hour wraps 12 to 01; the pm flip happens on 11 to 12 below
    rtc_bcd_inc #(.WIDTH(5)) u_h12 (
        .value   (state.hours[4:0]),
        .limit   (`BCD_12),
        .reload  (`BCD_01),
        .result  (h12_next),
        .wrapped ()
    );
    rtc_bcd_inc #(.WIDTH(6)) u_day (
        .value   (state.day),
        .limit   (last_day),
        .reload  (`BCD_DAY_01),
        .result  (day_next),
        .wrapped (day_wrap)
    );

    assign format_12h            = state.hours[`BIT_FORMAT_12H];    // RULE_04
    assign pm_or_tens_twenty_bit = state.hours[`BIT_PM_OR_TWENTY];

    // bcd year divisible by four: tens even needs ones 0/4/8, tens odd 2/6
    always_comb
    begin
        if (YEAR[4] == 1'b0)
            leap_year = (YEAR[3:0] == 4'h0) || (YEAR[3:0] == 4'h4)
                      || (YEAR[3:0] == 4'h8);                       // RULE_08
        else
            leap_year = (YEAR[3:0] == 4'h2) || (YEAR[3:0] == 4'h6); // RULE_08
    end

    // month length; invalid month codes fall back to 31
    always_comb
    begin
        unique case (MONTH)
            `BCD_FEB: last_day = leap_year ? `BCD_DAY_29 : `BCD_DAY_28; // RULE_08
            `BCD_APR,
            `BCD_JUN,
            `BCD_SEP,
            `BCD_NOV: last_day = `BCD_DAY_30;
            default:  last_day = `BCD_DAY_31;
        endcase
    end

    // counting cascade, register writes and read mux
    always_comb
    begin
        next_state = state;
        MONTH_INC  = 1'b0;
        day_roll   = 1'b0;
        if (SECOND_TICK)
        begin
            next_state.seconds = sec_next;                          // RULE_02
            if (sec_wrap)
            begin
                next_state.minutes = min_next;                      // RULE_02
                if (min_wrap)
                begin
                    if (format_12h)
                    begin
                        next_state.hours[4:0] = h12_next;           // RULE_05
                        if (state.hours[4:0] == `BCD_11)
                            next_state.hours[`BIT_PM_OR_TWENTY] =
                                ~pm_or_tens_twenty_bit;             // RULE_05
                        if (state.hours[4:0] == `BCD_11 && pm_or_tens_twenty_bit)
                            day_roll = 1'b1;                        // RULE_09
                    end
                    else
                    begin
                        next_state.hours[5:0] = h24_next;           // RULE_06
                        if (h24_wrap)
                            day_roll = 1'b1;                        // RULE_09
                    end
                end
            end
        end
        // midnight: day and weekday advance together; days need no name
        if (day_roll)
        begin
            next_state.day = day_next;                              // RULE_09
            if (state.weekday == `WEEKDAY_LAST)
                next_state.weekday = `WEEKDAY_FIRST;                // RULE_10
            else
                next_state.weekday = state.weekday + 3'h1;          // RULE_11
            MONTH_INC = day_wrap;                                   // RULE_09
        end
        // a host write wins over the tick for the register it touches
        if (WRITE)
        begin
            unique case (ADDR)
                `ADDR_SECONDS:      next_state.seconds = WDATA[6:0];  // RULE_01
                `ADDR_MINUTES:      next_state.minutes = WDATA[6:0];  // RULE_03
                `ADDR_HOURS:        next_state.hours   = WDATA[6:0];  // RULE_04
                `ADDR_DAY_OF_MONTH: next_state.day     = WDATA[5:0];  // RULE_07
                `ADDR_WEEKDAY:      next_state.weekday = WDATA[2:0];  // RULE_10
                default: ;
            endcase
        end
        if (READ)
        begin
            unique case (ADDR)
                `ADDR_SECONDS:      next_state.rdata = {1'b0, state.seconds}; // RULE_13
                `ADDR_MINUTES:      next_state.rdata = {1'b0, state.minutes}; // RULE_13
                `ADDR_HOURS:        next_state.rdata = {1'b0, state.hours};   // RULE_13
                `ADDR_DAY_OF_MONTH: next_state.rdata = {2'b00, state.day};    // RULE_13
                `ADDR_WEEKDAY:      next_state.rdata = {5'h00, state.weekday}; // RULE_13
                default:            next_state.rdata = `BCD_00;
            endcase
        end
        if (RESET)
        begin
            next_state.seconds = `RESET_SECONDS;
            next_state.minutes = `RESET_MINUTES;
            next_state.hours   = `RESET_HOURS;
            next_state.day     = `RESET_DAY;
            next_state.weekday = `RESET_WEEKDAY;
            next_state.rdata   = `BCD_00;
            MONTH_INC          = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge MCLK)
    begin
        state <= next_state;
    end

    assign RDATA = state.rdata;
endmodule : rtc_time_date_counters

/* rtc_defines.svh */
// register offsets, field positions and limits of the time and date counters
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define ADDR_SECONDS      8'h08
`define ADDR_MINUTES      8'h09
`define ADDR_HOURS        8'h0a
`define ADDR_DAY_OF_MONTH 8'h0b
`define ADDR_WEEKDAY      8'h0c
`define MASK_SECONDS      8'h7f
`define MASK_MINUTES      8'h7f
`define MASK_HOURS        8'h7f
`define MASK_DAY          8'h3f
`define MASK_WEEKDAY      8'h07
`define BIT_FORMAT_12H    6
`define BIT_PM_OR_TWENTY  5
`define BCD_59            7'h59
`define BCD_23            6'h23
`define BCD_HOUR_00       6'h00
`define BCD_12            5'h12
`define BCD_11            5'h11
`define BCD_01            5'h01
`define BCD_00            8'h00
`define BCD_DAY_01        6'h01
`define BCD_DAY_28        6'h28
`define BCD_DAY_29        6'h29
`define BCD_DAY_30        6'h30
`define BCD_DAY_31        6'h31
`define BCD_FEB           5'h02
`define BCD_APR           5'h04
`define BCD_JUN           5'h06
`define BCD_SEP           5'h09
`define BCD_NOV           5'h11
`define WEEKDAY_FIRST     3'h1
`define WEEKDAY_LAST      3'h7
`define RESET_SECONDS     7'h00
`define RESET_MINUTES     7'h00
`define RESET_HOURS       7'h00
`define RESET_DAY         6'h01
`define RESET_WEEKDAY     3'h1
`endif

/* rtc_pkg.sv */
// types shared by the time and date counter block
package rtc_pkg;
    typedef struct packed {
        logic [6:0] seconds;
        logic [6:0] minutes;
        logic [6:0] hours;
        logic [5:0] day;
        logic [2:0] weekday;
        logic [7:0] rdata;
    } rtc_state_t;
    typedef struct packed {
        logic [3:0] ones;
        logic       carry;
    } bcd_step_t;
endpackage : rtc_pkg

/* rtc_bcd_inc.sv */
// one bcd digit-pair incrementer with wrap limit and reload value
`timescale 1ns/10ps
module rtc_bcd_inc #(
    parameter int WIDTH = 7
) (
    input  wire logic [WIDTH-1:0] value,    // current bcd value
    input  wire logic [WIDTH-1:0] limit,    // last value before wrap
    input  wire logic [WIDTH-1:0] reload,   // value after wrap
    output logic      [WIDTH-1:0] result,   // next value
    output logic                  wrapped   // high when limit reached
);
    logic [WIDTH-1:0] tens_step;
    // ones digit rolls at nine into the tens digit
    always_comb
    begin
        tens_step = value + WIDTH'(16);
        tens_step[3:0] = 4'h0;
        wrapped = (value == limit);
        if (wrapped)
            result = reload;
        else if (value[3:0] == 4'h9)
            result = tens_step;
        else
            result = value + WIDTH'(1);
    end
endmodule : rtc_bcd_inc

/* rtc_host_model.sv */
// host model driving the register strobes of the counters
`timescale 1ns/10ps
module rtc_host_model (
    input  wire logic       MCLK,  // clock
    input  wire logic [7:0] RDATA, // read data
    output logic      [7:0] ADDR,  // offset
    output logic            WRITE, // write strobe
    output logic      [7:0] WDATA, // write data
    output logic            READ   // read strobe
);
    initial {ADDR, WRITE, WDATA, READ} = '0;
    // one-cycle write; callers pass only valid bcd, the day names are theirs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK);
        ADDR = a;
        WDATA = d;
        WRITE = 1'b1;
        @(negedge MCLK);
        WRITE = 1'b0;
        WDATA = ~d; // stale data must not look valid
    endtask : wr
    // one-cycle read, data taken once the answering edge has passed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge MCLK);
        ADDR = a;
        READ = 1'b1;
        @(negedge MCLK);
        READ = 1'b0;
        d = RDATA;
    endtask : rd
endmodule : rtc_host_model

/* rtc_counters_sva.sv */
// port assertions for the time and date counters
`timescale 1ns/10ps
module rtc_counters_sva (
    input wire logic       MCLK,        // clock
    input wire logic       RESET,       // sync reset
    input wire logic       SECOND_TICK, // tick
    input wire logic [7:0] ADDR,        // offset
    input wire logic       WRITE,       // write strobe
    input wire logic [7:0] WDATA,       // write data
    input wire logic       READ,        // read strobe
    input wire logic [7:0] RDATA,       // read data
    input wire logic       MONTH_INC    // day wrap pulse
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // read data layout and write-back
    property p_sec; READ && ADDR == 8'h08 |=> !RDATA[7]; endproperty
    a_sec: assert property (p_sec) else $error("seconds top bit set");
    property p_min; WRITE && ADDR == 8'h09 ##1 !SECOND_TICK ##1 READ && ADDR == 8'h09
        |=> RDATA == ($past(WDATA, 3) & 8'h7f); endproperty
    a_min: assert property (p_min) else $error("minutes not written");
    property p_hr; READ && ADDR == 8'h0a |=> !RDATA[7]; endproperty
    a_hr: assert property (p_hr) else $error("hours top bit set");
    property p_day; READ && ADDR == 8'h0b |=> RDATA[7:6] == 2'b00 && RDATA[5:0] != 6'h00;
    endproperty
    a_day: assert property (p_day) else $error("day out of shape");
    property p_wd; READ && ADDR == 8'h0c |=> RDATA[7:3] == 5'h00 && RDATA[2:0] != 3'h0;
    endproperty
    a_wd: assert property (p_wd) else $error("weekday out of shape");
    property p_unm; READ && (ADDR < 8'h08 || ADDR > 8'h0c) |=> RDATA == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    // month advance only on a tick, never twice running
    property p_inc; MONTH_INC |-> SECOND_TICK; endproperty
    a_inc: assert property (p_inc) else $error("month advance without tick");
    property p_one; MONTH_INC |=> !MONTH_INC; endproperty
    a_one: assert property (p_one) else $error("month advance twice");
endmodule : rtc_counters_sva
bind rtc_time_date_counters rtc_counters_sva i_sva (.MCLK, .RESET, .SECOND_TICK, .ADDR,
    .WRITE, .WDATA, .READ, .RDATA, .MONTH_INC);

/* tb.sv */
// self-checking bench for the time and date counters
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
    logic       MCLK = 1'b0;
    logic       RESET = 1'b1;
    logic       SECOND_TICK = 1'b0;
    logic [4:0] MONTH = 5'h01;
    logic [6:0] YEAR = 7'h21;
    logic [7:0] ADDR, WDATA, RDATA, rv;
    logic       WRITE, READ, MONTH_INC;
    int         errors = 0;
    int         num_checks = 0;
    always #10 MCLK = ~MCLK;
    rtc_time_date_counters i_rtc_time_date_counters (.MCLK, .RESET, .SECOND_TICK, .ADDR,
        .WRITE, .WDATA, .READ, .RDATA, .MONTH, .YEAR, .MONTH_INC);
    rtc_host_model host (.MCLK, .RDATA, .ADDR, .WRITE, .WDATA, .READ);
    task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        `CHK($sformatf("reg_%h", a), e, rv)
    endtask : check_reg
    // month advance is combinational, so look inside the tick cycle
    task automatic tick(input logic e);
        @(negedge MCLK);
        SECOND_TICK = 1'b1;
        #1 `CHK("month_inc", e, MONTH_INC)
        @(negedge MCLK);
        SECOND_TICK = 1'b0;
    endtask : tick
    // load hr:59:59, weekday 7, one tick, then read everything back
    task automatic roll_one(input logic [4:0] m, input logic [6:0] y, input logic [7:0] hr,
        input logic [7:0] d, input logic e, input logic [7:0] ehr, ed, ewd);
        MONTH = m;
        YEAR = y;
        host.wr(8'h0a, hr);
        host.wr(8'h09, 8'h59);
        host.wr(8'h08, 8'h59);
        host.wr(8'h0b, d);
        host.wr(8'h0c, 8'h07);
        tick(e);
        check_reg(8'h08, 8'h00);
        check_reg(8'h09, 8'h00);
        check_reg(8'h0a, ehr);
        check_reg(8'h0b, ed);
        check_reg(8'h0c, ewd);
    endtask : roll_one
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    // main sequence
    initial
    begin
        repeat (6) @(posedge MCLK);
        @(negedge MCLK) RESET = 1'b0;
        check_reg(8'h08, 8'h00);
        check_reg(8'h0b, 8'h01);
        check_reg(8'h0c, 8'h01);
        $display("test reset done");
        roll_one(5'h02, 7'h21, 8'h23, 8'h28, 1, 8'h00, 8'h01, 8'h01);
        roll_one(5'h02, 7'h24, 8'h23, 8'h28, 0, 8'h00, 8'h29, 8'h01);
        roll_one(5'h02, 7'h00, 8'h23, 8'h29, 1, 8'h00, 8'h01, 8'h01);
        roll_one(5'h04, 7'h21, 8'h23, 8'h30, 1, 8'h00, 8'h01, 8'h01);
        roll_one(5'h01, 7'h21, 8'h23, 8'h30, 0, 8'h00, 8'h31, 8'h01);
        roll_one(5'h12, 7'h21, 8'h23, 8'h31, 1, 8'h00, 8'h01, 8'h01);
        $display("test day rollover done");
        roll_one(5'h01, 7'h21, 8'h51, 8'h10, 0, 8'h72, 8'h10, 8'h07);
        roll_one(5'h01, 7'h21, 8'h72, 8'h10, 0, 8'h61, 8'h10, 8'h07);
        roll_one(5'h01, 7'h21, 8'h71, 8'h10, 0, 8'h52, 8'h11, 8'h01);
        $display("test twelve hour done");
        host.wr(8'h08, 8'hd9);
        host.wr(8'h0a, 8'h93);
        host.wr(8'h0c, 8'hfd);
        host.wr(8'h20, 8'h33);
        host.wr(8'h09, 8'hc7);
        check_reg(8'h09, 8'h47);
        check_reg(8'h08, 8'h59);
        check_reg(8'h0a, 8'h13);
        check_reg(8'h0c, 8'h05);
        check_reg(8'h20, 8'h00);
        $display("test unused bits done");
        final_report;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge MCLK);
        errors++;
        final_report;
    end
endmodule : tb
